// [bench/drive_model.sv]
`timescale 1ns/10ps
`default_nettype none
module drive_model (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // Design side
   input  wire logic       seekReq,
   input  wire logic [7:0] rdByte,
   output logic            tick,
   output logic      [7:0] rdData,
   output logic            seekDone
);
   logic [1:0] div_q;
   logic [2:0] seekWait_q;
   // Byte slot every fourth clock; read data toggles outside the slot so it is never stale
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         div_q      <= 2'h0;
         tick       <= 1'b0;
         rdData     <= 8'h00;
         seekWait_q <= 3'h0;
         seekDone   <= 1'b0;
      end else begin
         div_q    <= div_q + 2'h1;
         tick     <= (div_q == 2'h3);
         rdData   <= (div_q == 2'h3) ? rdByte : ~rdData;
         seekDone <= (seekWait_q == 3'h1);
         if (seekReq) begin
            seekWait_q <= 3'h5;
         end else if (seekWait_q != 3'h0) begin
            seekWait_q <= seekWait_q - 3'h1;
         end
      end
   end
endmodule : drive_model
`default_nettype wire

// [bench/floppy_command_parameter_decode_test.sv]
`timescale 1ns/10ps
`default_nettype none
`include "fdc_param_defs.svh"
module floppy_command_parameter_decode_test;
   import fdc_param_pkg::*;
   logic       clock = 1'b0;
   logic       reset = 1'b1;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWrData = 8'h00;
   logic       regWr = 1'b0;
   logic       regRd = 1'b0;
   logic [7:0] regRdData_q, diskWrData_q, gap2Length_q, gap3Length_q, sectorId_q;
   logic [7:0] hostRdData_q, diskRdData;
   logic [7:0] hostWrData = 8'ha5;
   logic [7:0] rdByte = 8'h6d;
   logic [3:0] driveSelect_q;
   logic       seekReq_q, headLoad_q, diskSide_q, fifoEnable_q, hostRdValid_q, hostWrTake_q;
   logic       diskByteTick, seekDone, hlPrev = 1'b0;
   int         n_fail = 0, total_checks = 0, cyc = 0, rdCnt = 0, wrCnt = 0, seekCnt = 0;
   int         rdBase = 0, firstRd = 0, loadAt = 0;

   floppy_command_parameter_decode #(.TICK_CYCLES(4)) dut_u (
      .clock(clock), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData_q(regRdData_q),
      .diskByteTick(diskByteTick), .diskRdData(diskRdData), .seekDone(seekDone),
      .diskWrData_q(diskWrData_q), .seekReq_q(seekReq_q), .headLoad_q(headLoad_q),
      .driveSelect_q(driveSelect_q), .diskSide_q(diskSide_q), .gap2Length_q(gap2Length_q),
      .gap3Length_q(gap3Length_q), .sectorId_q(sectorId_q), .fifoEnable_q(fifoEnable_q),
      .hostWrData(hostWrData), .hostRdData_q(hostRdData_q), .hostRdValid_q(hostRdValid_q),
      .hostWrTake_q(hostWrTake_q)
   );
   drive_model drive_u (
      .clock(clock), .reset(reset), .seekReq(seekReq_q), .rdByte(rdByte),
      .tick(diskByteTick), .rdData(diskRdData), .seekDone(seekDone)
   );

   initial begin
      forever #2 clock = ~clock;
   end

   task automatic end_sim();
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Monitors sample before the edge's updates land
   always @(posedge clock) begin
      cyc <= cyc + 1;
      hlPrev <= headLoad_q;
      if (headLoad_q && !hlPrev) loadAt <= cyc;
      if (hostRdValid_q) begin
         if (rdCnt == rdBase) firstRd <= cyc;
         rdCnt <= rdCnt + 1;
         check("hostRdData", hostRdData_q, rdByte);
      end
      if (hostWrTake_q) wrCnt <= wrCnt + 1;
      if (hostWrTake_q) check("diskWrData", diskWrData_q, hostWrData);
      if (seekReq_q) seekCnt <= seekCnt + 1;
      if (cyc == 60000) begin
         n_fail++;
         end_sim();
      end
   end

   task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clock);
      regWr <= 1'b0;
      @(posedge clock);
   endtask : regWrite

   task automatic regRead(input logic [3:0] a, output logic [7:0] v);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clock);
      regRd <= 1'b0;
      #1 v = regRdData_q;
      @(posedge clock);
   endtask : regRead

   function automatic logic [15:0] crcOf(input logic [7:0] b, input int nData, input int nAll);
      logic [15:0] c;
      c = 16'hffff;
      for (int i = 0; i < nAll; i++) begin
         c = c ^ {(i < nData) ? b : 8'h00, 8'h00};
         for (int k = 0; k < 8; k++) c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
      end
      return c;
   endfunction : crcOf

   // Loads the parameters, starts one command and waits for completion
   task automatic runXfer(input logic [7:0] ctrl, cfg, size, xlen, first, last);
      logic [7:0] v;
      regWrite(`REG_CFG, cfg);
      regWrite(`REG_SIZE, size);
      regWrite(`REG_XLEN, xlen);
      regWrite(`REG_SECTOR, first);
      regWrite(`REG_LAST, last);
      rdBase = rdCnt;
      regWrite(`REG_CTRL, ctrl);
      for (int i = 0; i < 4000; i++) begin
         regRead(`REG_STATUS, v);
         if (v[7]) break;
      end
      check("done", v[7], 1'b1);
      regWrite(`REG_STATUS, 8'h80);
   endtask : runXfer

   task automatic checkCrc(input logic [15:0] exp);
      logic [7:0] lo, hi;
      regRead(`REG_CRC_LO, lo);
      regRead(`REG_CRC_HI, hi);
      check("crc", {hi, lo}, exp);
   endtask : checkCrc

   task automatic t_reset();
      logic [7:0] v;
      check("driveSelect", driveSelect_q, 4'h1);
      check("gap2", gap2Length_q, 8'h16);
      check("fifoEnable", fifoEnable_q, 1'b0);
      regRead(`REG_XLEN, v);
      check("xlen", v, 8'hff);
      regRead(`REG_CFG, v);
      check("cfg", v, 8'h01);
      regRead(4'he, v);
      check("unmapped", v, 8'h00);
   endtask : t_reset

   task automatic t_params();
      for (int d = 1; d < 4; d++) begin
         regWrite(`REG_DRIVE, {5'h0, d[0], d[1:0]});
         @(posedge clock);
         #1 check("driveSelect", driveSelect_q, 4'h1 << d);
         check("diskSide", diskSide_q, d[0]);
      end
      regWrite(`REG_CFG, 8'h00);
      #1 check("fifoOn", fifoEnable_q, 1'b1);
      regWrite(`REG_GAP3, 8'h2a);
      #1 check("gap3", gap3Length_q, 8'h2a);
   endtask : t_params

   task automatic t_read();
      int s0;
      s0 = seekCnt;
      regWrite(`REG_SETTLE, 8'h03);
      regWrite(`REG_RELEASE, 8'h08);
      regWrite(`REG_GAP2, 8'h0c);
      runXfer(8'h09, 8'h03, 8'h00, 8'h04, 8'h01, 8'h02);
      check("hostBytes", rdCnt - rdBase, 16'd8);
      check("seeks", seekCnt - s0, 16'd1);
      check("settle", (firstRd - loadAt) >= 8, 1'b1);
      check("lastSector", sectorId_q, 8'h02);
      check("gap2", gap2Length_q, 8'h0c);
      check("headHeld", headLoad_q, 1'b1);
      checkCrc(crcOf(8'h6d, 128, 128));
      for (int i = 0; i < 80 && headLoad_q; i++) @(posedge clock);
      check("headReleased", headLoad_q, 1'b0);
   endtask : t_read

   task automatic t_write();
      int s0, w0;
      s0 = seekCnt;
      w0 = wrCnt;
      runXfer(8'h03, 8'h01, 8'h00, 8'h02, 8'h03, 8'h03);
      check("hostTakes", wrCnt - w0, 16'd2);
      check("noSeek", seekCnt - s0, 16'd0);
      check("fillByte", diskWrData_q, 8'h00);
      check("gap2Std", gap2Length_q, 8'h16);
      checkCrc(crcOf(8'ha5, 2, 128));
      w0 = wrCnt;
      runXfer(8'h03, 8'h01, 8'h01, 8'hff, 8'h01, 8'h01);
      check("fullTakes", wrCnt - w0, 16'd256);
      check("lastWrByte", diskWrData_q, 8'ha5);
      checkCrc(crcOf(8'ha5, 256, 256));
   endtask : t_write

   task automatic t_verify();
      runXfer(8'h05, 8'h05, 8'h00, 8'h02, 8'h01, 8'h09);
      check("verifyHost", rdCnt - rdBase, 16'd0);
      check("verifyCount", sectorId_q, 8'h02);
   endtask : t_verify

   initial begin
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      t_reset();
      t_params();
      t_read();
      t_write();
      t_verify();
      end_sim();
   end
endmodule : floppy_command_parameter_decode_test
`default_nettype wire

// [include/byte_stream_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface byte_stream_if;
   logic        valid;
   logic        first;
   logic [7:0]  data;
   logic [15:0] crc;
   modport src  (output valid, output first, output data, input crc);
   modport sink (input valid, input first, input data, output crc);
endinterface : byte_stream_if
`default_nettype wire

// [include/fdc_param_defs.svh]
`ifndef FDC_PARAM_DEFS_SVH
`define FDC_PARAM_DEFS_SVH
// Register offsets
`define REG_CTRL    4'h0
`define REG_DRIVE   4'h1
`define REG_SIZE    4'h2
`define REG_XLEN    4'h3
`define REG_LAST    4'h4
`define REG_GAP3    4'h5
`define REG_GAP2    4'h6
`define REG_CFG     4'h7
`define REG_SETTLE  4'h8
`define REG_RELEASE 4'h9
`define REG_SECTOR  4'ha
`define REG_STATUS  4'hb
`define REG_CRC_LO  4'hc
`define REG_CRC_HI  4'hd
// Control bit positions
`define CTRL_START  0
`define CTRL_WRITE  1
`define CTRL_VERIFY 2
`define CTRL_PERP   3
// Configuration bit positions and reset value
`define CFG_FIFO_OFF 0
`define CFG_SEEK     1
`define CFG_COUNT    2
`define CFG_RESET    3'h1
// Status bit positions
`define STAT_DONE 7
// Sector, gap and CRC constants
`define SECTOR_BASE_LEN 15'h0080
`define WRITE_FILL      8'h00
`define GAP2_STD        8'h16
`define CRC_INIT        16'hffff
`define CRC_POLY        16'h1021
// Head interval unit and clock
`define HEAD_UNIT_NS  1000000
`define CLK_PERIOD_NS 4
`endif

// [include/fdc_param_pkg.sv]
package fdc_param_pkg;
   typedef enum logic [2:0] {sIdle, sSeek, sSettle, sXfer, sHold} state_t;
   typedef logic [14:0] byte_count_t;
endpackage : fdc_param_pkg

// [logic/floppy_command_parameter_decode.sv]
// Operation
// - Size code 0 means a 128-byte sector and codes up to 7 mean 128 shifted left by the code.
// - With size code 0 the special transfer length is the byte count passed to or from the host.
// - On reads past the special length the rest of the sector is read but not handed to the host.
// - On writes past the special length the rest of the sector is filled with zero bytes.
// - The sector CRC covers the whole physical sector.
// - In verify with count enable set, the special length is the number of sectors per track.
// - The FIFO disable bit is active high, 0 enables the FIFO, 1 disables it and is the default.
// - With implied seek set a seek precedes every read or write, otherwise none happens.
// - The last track sector parameter is the number of the final sector processed on the track.
// - In perpendicular mode the gap 2 length follows the perpendicular gap parameter.
// - The intersector gap length is the gap 3 size between sectors.
// - The disk side select is 0 or 1 and picks the matching side of the disk.
// - After the head loads, the settle interval passes before any read or write begins; the timer counts whole ticks, so it can end up to one tick early.
// - The head stays loaded for the release interval after a transfer ends, then unloads; the timer counts whole ticks, so it can unload up to one tick early.
`timescale 1ns/10ps
`default_nettype none
`include "fdc_param_defs.svh"
module floppy_command_parameter_decode
   import fdc_param_pkg::*;
#(
   parameter int TICK_CYCLES = `HEAD_UNIT_NS / `CLK_PERIOD_NS
) (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // Register port
   input  wire logic [3:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output logic      [7:0] regRdData_q,
   // Drive side
   input  wire logic       diskByteTick,
   input  wire logic [7:0] diskRdData,
   input  wire logic       seekDone,
   output logic      [7:0] diskWrData_q,
   output logic            seekReq_q,
   output logic            headLoad_q,
   output logic      [3:0] driveSelect_q,
   output logic            diskSide_q,
   output logic      [7:0] gap2Length_q,
   output logic      [7:0] gap3Length_q,
   output logic      [7:0] sectorId_q,
   output logic            fifoEnable_q,
   // Host data side
   input  wire logic [7:0] hostWrData,
   output logic      [7:0] hostRdData_q,
   output logic            hostRdValid_q,
   output logic            hostWrTake_q
);
   state_t      state_q;
   state_t      state_d;
   logic [3:0]  ctrl_q;
   logic [2:0]  drive_q;
   logic [2:0]  sizeCode_q;
   logic [7:0]  xferLen_q;
   logic [7:0]  lastSector_q;
   logic [7:0]  gap3_q;
   logic [7:0]  gap2_q;
   logic [2:0]  cfg_q;
   logic [7:0]  settle_q;
   logic [7:0]  release_q;
   logic        done_q;
   logic [19:0] tickCnt_q;
   logic        tick_q;
   byte_count_t byteIdx_q;
   logic [7:0]  sectCnt_q;

   // Register port decode
   wire wrCtrl    = regWr && regAddr == `REG_CTRL;
   wire wrDrive   = regWr && regAddr == `REG_DRIVE;
   wire wrSector  = regWr && regAddr == `REG_SECTOR;
   wire wrStatus  = regWr && regAddr == `REG_STATUS;
   wire startCmd  = wrCtrl && regWrData[`CTRL_START]
                    && (state_q == sIdle || state_q == sHold);
   wire isWrite   = ctrl_q[`CTRL_WRITE];
   wire isVerify  = ctrl_q[`CTRL_VERIFY];
   wire countMode = isVerify && cfg_q[`CFG_COUNT];
   wire seekOn    = cfg_q[`CFG_SEEK];

   // Sector geometry
   wire byte_count_t sectorLen = `SECTOR_BASE_LEN << sizeCode_q;
   wire byte_count_t hostLen   = (sizeCode_q == 3'h0)
                                 ? {7'h00, xferLen_q} : sectorLen;
   wire inHost    = byteIdx_q < hostLen;
   wire lastByte  = byteIdx_q == sectorLen - 15'h0001;
   wire [7:0] sectNext = sectCnt_q + 8'h01;
   wire lastSect  = countMode ? (sectNext == xferLen_q)
                              : (sectorId_q == lastSector_q);
   wire step      = state_q == sXfer && diskByteTick;
   wire sectEnd   = step && lastByte;
   wire trackEnd  = sectEnd && lastSect;
   wire [7:0] wrByte = inHost ? hostWrData : `WRITE_FILL;

   // Head timers
   logic settleDone;
   logic releaseDone;
   wire  enterSettle  = state_d == sSettle && state_q != sSettle;
   wire  enterRelease = state_d == sHold && state_q == sXfer;

   interval_timer u_settle (
      .clock    (clock),
      .reset    (reset),
      .start    (enterSettle),
      .cancel   (1'b0),
      .tick     (tick_q),
      .interval (settle_q),
      .expired  (settleDone)
   );

   interval_timer u_release (
      .clock    (clock),
      .reset    (reset),
      .start    (enterRelease),
      .cancel   (startCmd),
      .tick     (tick_q),
      .interval (release_q),
      .expired  (releaseDone)
   );

   // CRC runs over every byte slot of the sector, host cut-off or not
   byte_stream_if crcBus ();
   assign crcBus.valid = step;
   assign crcBus.first = byteIdx_q == 15'h0000;
   assign crcBus.data  = isWrite ? wrByte : diskRdData;

   sector_crc u_crc (
      .clock (clock),
      .reset (reset),
      .bytes (crcBus)
   );

   // Sequencer
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         sIdle, sHold: begin
            if (startCmd) begin
               state_d = seekOn ? sSeek : (headLoad_q ? sXfer : sSettle);
            end else if (state_q == sHold && releaseDone) begin
               state_d = sIdle;
            end
         end
         sSeek: begin
            if (seekDone) begin
               state_d = headLoad_q ? sXfer : sSettle;
            end
         end
         sSettle: begin
            if (settleDone) begin
               state_d = sXfer;
            end
         end
         sXfer: begin
            if (trackEnd) begin
               state_d = sHold;
            end
         end
      endcase
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_q <= sIdle;
      end else begin
         state_q <= state_d;
      end
   end

   // Interval tick divider; the unit is long, so a slow enable beats wide timers
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         tickCnt_q <= 20'h00000;
         tick_q    <= 1'b0;
      end else begin
         tick_q    <= tickCnt_q == 20'(TICK_CYCLES - 1);
         tickCnt_q <= (tickCnt_q == 20'(TICK_CYCLES - 1)) ? 20'h00000
                                                          : tickCnt_q + 20'h00001;
      end
   end

   // Parameter registers
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ctrl_q       <= 4'h0;
         drive_q      <= 3'h0;
         sizeCode_q   <= 3'h0;
         xferLen_q    <= 8'hff;
         lastSector_q <= 8'h00;
         gap3_q       <= 8'h00;
         gap2_q       <= 8'h00;
         cfg_q        <= `CFG_RESET;
         settle_q     <= 8'h00;
         release_q    <= 8'h00;
      end else if (regWr) begin
         unique case (regAddr)
            `REG_CTRL:    ctrl_q       <= regWrData[3:0];
            `REG_DRIVE:   drive_q      <= regWrData[2:0];
            `REG_SIZE:    sizeCode_q   <= regWrData[2:0];
            `REG_XLEN:    xferLen_q    <= regWrData;
            `REG_LAST:    lastSector_q <= regWrData;
            `REG_GAP3:    gap3_q       <= regWrData;
            `REG_GAP2:    gap2_q       <= regWrData;
            `REG_CFG:     cfg_q        <= regWrData[2:0];
            `REG_SETTLE:  settle_q     <= regWrData;
            `REG_RELEASE: release_q    <= regWrData;
            default: ;
         endcase
      end
   end

   // Decoded drive-facing parameters
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         driveSelect_q <= 4'h1;
         diskSide_q    <= 1'b0;
         fifoEnable_q  <= 1'b0;
         gap2Length_q  <= `GAP2_STD;
         gap3Length_q  <= 8'h00;
      end else begin
         driveSelect_q <= 4'h1 << drive_q[1:0];
         diskSide_q    <= drive_q[2];
         fifoEnable_q  <= !cfg_q[`CFG_FIFO_OFF];
         gap2Length_q  <= ctrl_q[`CTRL_PERP] ? gap2_q : `GAP2_STD;
         gap3Length_q  <= gap3_q;
      end
   end

   // Head load and seek request
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         headLoad_q <= 1'b0;
         seekReq_q  <= 1'b0;
      end else begin
         seekReq_q <= state_d == sSeek && state_q != sSeek;
         if (enterSettle) begin
            headLoad_q <= 1'b1;
         end else if (state_q == sHold && state_d == sIdle) begin
            headLoad_q <= 1'b0;
         end
      end
   end

   // Byte and sector progress; the drive clocks the whole sector regardless of host length
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         byteIdx_q  <= 15'h0000;
         sectCnt_q  <= 8'h00;
         sectorId_q <= 8'h00;
      end else begin
         if (startCmd) begin
            byteIdx_q <= 15'h0000;
            sectCnt_q <= 8'h00;
         end else if (step) begin
            byteIdx_q <= lastByte ? 15'h0000 : byteIdx_q + 15'h0001;
            if (lastByte) begin
               sectCnt_q <= sectNext;
            end
         end
         if (sectEnd && !lastSect) begin
            sectorId_q <= sectorId_q + 8'h01;
         end else if (wrSector) begin
            sectorId_q <= regWrData;
         end
      end
   end

   // Data path to host and drive
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         diskWrData_q  <= 8'h00;
         hostRdData_q  <= 8'h00;
         hostRdValid_q <= 1'b0;
         hostWrTake_q  <= 1'b0;
      end else begin
         hostRdValid_q <= step && !isWrite && !isVerify && inHost;
         hostWrTake_q  <= step && isWrite && inHost;
         if (step && !isWrite) begin
            hostRdData_q <= diskRdData;
         end
         if (step && isWrite) begin
            diskWrData_q <= wrByte;
         end
      end
   end

   // Completion flag: a finish in the clearing cycle still sets it
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         done_q <= 1'b0;
      end else if (trackEnd) begin
         done_q <= 1'b1;
      end else if (wrStatus && regWrData[`STAT_DONE]) begin
         done_q <= 1'b0;
      end
   end

   // Read back; unmapped offsets read zero
   wire [7:0] statusByte = {done_q, headLoad_q, fifoEnable_q, 2'b00, state_q};
   logic [7:0] rdMux;
   always_comb begin
      unique case (regAddr)
         `REG_CTRL:    rdMux = {4'h0, ctrl_q};
         `REG_DRIVE:   rdMux = {5'h00, drive_q};
         `REG_SIZE:    rdMux = {5'h00, sizeCode_q};
         `REG_XLEN:    rdMux = xferLen_q;
         `REG_LAST:    rdMux = lastSector_q;
         `REG_GAP3:    rdMux = gap3_q;
         `REG_GAP2:    rdMux = gap2_q;
         `REG_CFG:     rdMux = {5'h00, cfg_q};
         `REG_SETTLE:  rdMux = settle_q;
         `REG_RELEASE: rdMux = release_q;
         `REG_SECTOR:  rdMux = sectorId_q;
         `REG_STATUS:  rdMux = statusByte;
         `REG_CRC_LO:  rdMux = crcBus.crc[7:0];
         `REG_CRC_HI:  rdMux = crcBus.crc[15:8];
         default:      rdMux = 8'h00;
      endcase
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         regRdData_q <= 8'h00;
      end else begin
         regRdData_q <= regRd ? rdMux : 8'h00;
      end
   end

   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   property p_drive;
      regWr && regAddr == `REG_DRIVE && regWrData[1:0] == 2'b10 |-> ##2 driveSelect_q == 4'h4;
   endproperty
   a_drive: assert property (p_drive) else $error("drive 2 not selected");
   property p_size;
      step && sizeCode_q == 3'h2 && byteIdx_q == 15'h01ff |=> byteIdx_q == 15'h0000;
   endproperty
   a_size: assert property (p_size) else $error("512-byte sector not closed");
   property p_short_rd;
      step && !isWrite && !isVerify && sizeCode_q == 3'h0 && byteIdx_q < {7'h00, xferLen_q}
         |=> hostRdValid_q && hostRdData_q == $past(diskRdData);
   endproperty
   a_short_rd: assert property (p_short_rd) else $error("host byte missing");
   property p_withhold;
      step && !isWrite && !inHost |=> !hostRdValid_q;
   endproperty
   a_withhold: assert property (p_withhold) else $error("extra byte passed to host");
   property p_fill;
      step && isWrite && !inHost |=> diskWrData_q == 8'h00 && !hostWrTake_q;
   endproperty
   a_fill: assert property (p_fill) else $error("fill byte not zero");
   property p_crc;
      step && !inHost && byteIdx_q != 15'h0000
         |-> crcBus.valid && !crcBus.first && crcBus.data == (isWrite ? `WRITE_FILL : diskRdData);
   endproperty
   a_crc: assert property (p_crc) else $error("CRC skipped tail bytes");
   property p_count;
      sectEnd && countMode && sectNext == xferLen_q |=> state_q == sHold && done_q;
   endproperty
   a_count: assert property (p_count) else $error("sector count end missed");
   property p_fifo;
      ##1 fifoEnable_q == !$past(cfg_q[`CFG_FIFO_OFF]);
   endproperty
   a_fifo: assert property (p_fifo) else $error("FIFO enable polarity wrong");
   property p_seek;
      startCmd && seekOn |=> seekReq_q && state_q == sSeek ##1 !seekReq_q;
   endproperty
   a_seek: assert property (p_seek) else $error("implied seek missing");
   property p_eot;
      sectEnd && !countMode && sectorId_q == lastSector_q |=> state_q == sHold;
   endproperty
   a_eot: assert property (p_eot) else $error("did not stop at last sector");
   property p_settle;
      $rose(headLoad_q) && settle_q >= 8'h02 |-> state_q == sSettle [*2];
   endproperty
   a_settle: assert property (p_settle) else $error("transfer before settle");
   property p_release;
      state_q == sHold && releaseDone && !startCmd |=> !headLoad_q && state_q == sIdle;
   endproperty
   a_release: assert property (p_release) else $error("head not released");

   c_write:  cover property (trackEnd && isWrite);
   c_short:  cover property (sectEnd && sizeCode_q == 3'h0 && xferLen_q < 8'h80);
   c_unload: cover property (state_q == sHold ##1 state_q == sIdle);
endmodule : floppy_command_parameter_decode
`default_nettype wire

// [logic/interval_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module interval_timer (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // Control
   input  wire logic       start,
   input  wire logic       cancel,
   input  wire logic       tick,
   input  wire logic [7:0] interval,
   // Status
   output logic            expired
);
   logic [7:0] count_q;
   logic       running_q;

   // Counts whole ticks, so expiry lands up to one tick early
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         count_q   <= 8'h00;
         running_q <= 1'b0;
      end else if (start) begin
         count_q   <= interval;
         running_q <= 1'b1;
      end else if (cancel) begin
         running_q <= 1'b0;
      end else if (running_q && tick && count_q != 8'h00) begin
         count_q <= count_q - 8'h01;
      end
   end

   // Not gated by start: the caller ignores expiry in its start cycle, and gating would loop
   assign expired = running_q && count_q == 8'h00;
endmodule : interval_timer
`default_nettype wire

// [logic/sector_crc.sv]
`timescale 1ns/10ps
`default_nettype none
`include "fdc_param_defs.svh"
module sector_crc (
   // Clock and reset
   input  wire logic clock,
   input  wire logic reset,
   // Byte stream
   byte_stream_if.sink bytes
);
   logic [15:0] crc_q;
   logic [15:0] seed;
   logic [15:0] next;

   assign seed = bytes.first ? `CRC_INIT : crc_q;

   always_comb begin
      next = seed ^ {bytes.data, 8'h00};
      for (int i = 0; i < 8; i++) begin
         next = next[15] ? ((next << 1) ^ `CRC_POLY) : (next << 1);
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         crc_q <= `CRC_INIT;
      end else if (bytes.valid) begin
         crc_q <= next;
      end
   end

   assign bytes.crc = crc_q;
endmodule : sector_crc
`default_nettype wire
